/* File: hw/ocfs_pkg.sv */
// Constants shared by the output clock frequency select block
`default_nettype none
package ocfs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] REG_SEL_AB   = 8'h60;
    localparam logic [7:0] REG_SEL_CD   = 8'h61;
    localparam logic [7:0] REG_SEL_EF   = 8'h62;
    localparam logic [7:0] REG_SEL_G    = 8'h63;
    localparam logic [7:0] REG_AUX_MODE = 8'h64;
    localparam logic [7:0] REG_MAIN     = 8'h65;
    localparam logic [7:0] REG_DIGCFG   = 8'h66;
    localparam logic [7:0] REG_STATUS   = 8'h67;
    localparam int         NUM_SEL_REGS = 4;
    localparam int         NUM_PORTS    = 7;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Field positions
    localparam int MODE_LSB     = 0;
    localparam int BORROW_FLSB  = 4;
    localparam int BORROW_BIT   = 6;
    localparam int DIG1_LSB     = 0;
    localparam int DIG1_SONET   = 2;
    localparam int DIG2_LSB     = 3;
    localparam int DIG2_SONET   = 5;
    localparam int SYNC_SRC_BIT = 7;
    localparam int NIB          = 4;

    // Path mode codes
    localparam logic [2:0] MAIN_BAD_MIN   = 3'h6;
    localparam logic [2:0] AUX_BORROW_OFS = 3'h2;

    // Port selector codes
    localparam logic [3:0] SEL_OFF  = 4'h0;
    localparam logic [3:0] SEL_2K   = 4'h1;
    localparam logic [3:0] SEL_8K   = 4'h2;
    localparam logic [3:0] SEL_DIG2 = 4'h3;
    localparam logic [3:0] SEL_DIG1 = 4'h4;
    localparam logic [3:0] SEL_M48  = 4'h5;
    localparam logic [3:0] SEL_M16  = 4'h6;
    localparam logic [3:0] SEL_M12  = 4'h7;
    localparam logic [3:0] SEL_M8   = 4'h8;
    localparam logic [3:0] SEL_M6   = 4'h9;
    localparam logic [3:0] SEL_M4   = 4'ha;
    localparam logic [3:0] SEL_A64  = 4'hb;
    localparam logic [3:0] SEL_A48  = 4'hc;
    localparam logic [3:0] SEL_A16  = 4'hd;
    localparam logic [3:0] SEL_A8   = 4'he;
    localparam logic [3:0] SEL_A4   = 4'hf;

    // Port positions with exceptions
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // Route kinds
    localparam logic [2:0] K_OFF   = 3'h0;
    localparam logic [2:0] K_2K    = 3'h1;
    localparam logic [2:0] K_8K    = 3'h2;
    localparam logic [2:0] K_DIG2  = 3'h3;
    localparam logic [2:0] K_DIG1  = 3'h4;
    localparam logic [2:0] K_MAIN  = 3'h5;
    localparam logic [2:0] K_AUX   = 3'h6;
    localparam logic [2:0] K_MAIN1 = 3'h7;

    // Divider bank taps
    localparam int NUM_DIVS = 8;
    localparam logic [2:0] D2  = 3'h0;
    localparam logic [2:0] D4  = 3'h1;
    localparam logic [2:0] D6  = 3'h2;
    localparam logic [2:0] D8  = 3'h3;
    localparam logic [2:0] D12 = 3'h4;
    localparam logic [2:0] D16 = 3'h5;
    localparam logic [2:0] D48 = 3'h6;
    localparam logic [2:0] D64 = 3'h7;
    localparam int DIV_RATIO [NUM_DIVS] = '{2, 4, 6, 8, 12, 16, 48, 64};
    localparam int DIV_WRAP = 192;
    localparam int CNT_W    = 8;

    typedef enum logic [1:0] {
        OCFS_IDLE = 2'b01,
        OCFS_ACK  = 2'b10
    } ocfs_bus_e;
endpackage
`default_nettype wire

/* File: hw/ocfs_divbank.sv */
// Free-running tick divider giving square waves at every tap ratio
`default_nettype none
module ocfs_divbank import ocfs_pkg::*; (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                tick,
    output logic [NUM_DIVS-1:0]      sq_q
);
    logic [CNT_W-1:0]    cnt_q;
    logic [CNT_W-1:0]    cnt_d;
    logic [NUM_DIVS-1:0] sq_d;

    // One counter wrapping at a common multiple keeps every tap phase-stable
    always_comb begin
        cnt_d = cnt_q;
        if (tick) begin
            cnt_d = (cnt_q == CNT_W'(DIV_WRAP - 1)) ? '0 : cnt_q + 1'b1;
        end
    end

    for (genvar i = 0; i < NUM_DIVS; i++) begin : g_tap
        always_comb begin
            sq_d[i] = (int'(cnt_q) % DIV_RATIO[i]) < (DIV_RATIO[i] / 2);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            sq_q  <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            sq_q  <= sq_d;
        end
    end
endmodule
`default_nettype wire

/* File: hw/ocfs_top.sv */
// Output clock frequency select: path modes and seven port source muxes
`default_nettype none
module ocfs_top import ocfs_pkg::*; #(
    parameter int ADDR_W = 10
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    input  wire logic              main_tick,
    input  wire logic              aux_tick,
    input  wire logic              main_2k,
    input  wire logic              main_8k,
    input  wire logic              aux_2k,
    input  wire logic              aux_8k,
    input  wire logic              prog_freq_first,
    input  wire logic              prog_freq_second,
    output logic                   out_port_a,
    output logic                   out_port_b,
    output logic                   out_port_c,
    output logic                   out_port_d,
    output logic                   out_port_e,
    output logic                   out_port_f,
    output logic                   out_port_g,
    output logic [2:0]             main_pll_code,
    output logic                   main_mode_bad,
    output logic [2:0]             aux_pll_code,
    output logic [2:0]             prog_freq_first_cfg,
    output logic [2:0]             prog_freq_second_cfg
);
    // ==========================================================
    // Register bus
    ocfs_bus_e        st_q;
    ocfs_bus_e        st_d;
    logic [7:0]       sel_q [NUM_SEL_REGS];
    logic [7:0]       sel_d [NUM_SEL_REGS];
    logic [7:0]       aux_q;
    logic [7:0]       aux_d;
    logic [7:0]       main_q;
    logic [7:0]       main_d;
    logic [7:0]       dig_q;
    logic [7:0]       dig_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic             wait_q;
    logic             wait_d;
    logic [7:0]       idx;
    logic             wr_go;
    logic [NUM_PORTS-1:0] out_q;
    logic [NUM_PORTS-1:0] out_d;

    assign idx   = address[ADDR_W-1:2];
    assign wr_go = write && (st_q == OCFS_ACK);

    always_comb begin
        st_d    = st_q;
        wait_d  = wait_q;
        rdata_d = rdata_q;
        sel_d   = sel_q;
        aux_d   = aux_q;
        main_d  = main_q;
        dig_d   = dig_q;
        case (st_q)
            OCFS_IDLE: begin
                if (read || write) begin
                    st_d    = OCFS_ACK;
                    wait_d  = 1'b0;
                    rdata_d = '0;
                    if (idx >= REG_SEL_AB && idx <= REG_SEL_G) begin
                        rdata_d[7:0] = sel_q[2'(idx - REG_SEL_AB)];
                    end else if (idx == REG_AUX_MODE) begin
                        rdata_d[7:0] = aux_q;
                    end else if (idx == REG_MAIN) begin
                        rdata_d[7:0] = main_q;
                    end else if (idx == REG_DIGCFG) begin
                        rdata_d[7:0] = dig_q;
                    end else if (idx == REG_STATUS) begin
                        rdata_d[NUM_PORTS-1:0] = out_q;
                    end
                end
            end
            OCFS_ACK: begin
                st_d   = OCFS_IDLE;
                wait_d = 1'b1;
                if (wr_go) begin
                    if (idx >= REG_SEL_AB && idx <= REG_SEL_G) begin
                        sel_d[2'(idx - REG_SEL_AB)] = writedata[7:0];
                    end else if (idx == REG_AUX_MODE) begin
                        aux_d = writedata[7:0];
                    end else if (idx == REG_MAIN) begin
                        main_d = writedata[7:0];
                    end else if (idx == REG_DIGCFG) begin
                        dig_d = writedata[7:0];
                    end
                end
            end
            default: begin
                st_d   = OCFS_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= OCFS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= '0;
            for (int i = 0; i < NUM_SEL_REGS; i++) begin
                sel_q[i] <= REG_RESET;
            end
            aux_q   <= REG_RESET;
            main_q  <= REG_RESET;
            dig_q   <= REG_RESET;
        end else if (ce) begin
            st_q    <= st_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            sel_q   <= sel_d;
            aux_q   <= aux_d;
            main_q  <= main_d;
            dig_q   <= dig_d;
        end
    end

    assign readdata    = rdata_q;
    assign waitrequest = wait_q;

    // ==========================================================
    // Path mode outputs
    logic [2:0] mpc_d;
    logic       mbad_d;
    logic [2:0] apc_d;
    logic [2:0] pf1_d;
    logic [2:0] pf2_d;
    logic [2:0] mpc_q;
    logic       mbad_q;
    logic [2:0] apc_q;
    logic [2:0] pf1_q;
    logic [2:0] pf2_q;

    always_comb begin
        mpc_d  = main_q[MODE_LSB +: 3];
        // Forbidden codes are stored as written but flagged for software
        mbad_d = main_q[MODE_LSB +: 3] >= MAIN_BAD_MIN;
        // Borrowed main frequencies reuse the aux code of the same mode
        apc_d  = main_q[BORROW_BIT]
               ? 3'({1'b0, main_q[BORROW_FLSB +: 2]} + AUX_BORROW_OFS)
               : aux_q[MODE_LSB +: 3];
        pf1_d  = {dig_q[DIG1_SONET], dig_q[DIG1_LSB +: 2]};
        pf2_d  = {dig_q[DIG2_SONET], dig_q[DIG2_LSB +: 2]};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mpc_q  <= '0;
            mbad_q <= 1'b0;
            apc_q  <= '0;
            pf1_q  <= '0;
            pf2_q  <= '0;
        end else if (ce) begin
            mpc_q  <= mpc_d;
            mbad_q <= mbad_d;
            apc_q  <= apc_d;
            pf1_q  <= pf1_d;
            pf2_q  <= pf2_d;
        end
    end

    assign main_pll_code        = mpc_q;
    assign main_mode_bad        = mbad_q;
    assign aux_pll_code         = apc_q;
    assign prog_freq_first_cfg  = pf1_q;
    assign prog_freq_second_cfg = pf2_q;

    // ==========================================================
    // Port source muxes
    logic [NUM_DIVS-1:0] msq;
    logic [NUM_DIVS-1:0] asq;
    logic [3:0]          code [NUM_PORTS];

    // Dividers never stop, so switching taps lands on a running waveform
    ocfs_divbank u_main_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .tick    (main_tick),
        .sq_q    (msq)
    );
    ocfs_divbank u_aux_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .tick    (aux_tick),
        .sq_q    (asq)
    );

    function automatic logic [5:0] route(input int p, input logic [3:0] c);
        logic [5:0] r;
        r = {K_OFF, D2};
        case (c)
            SEL_OFF:  r = {K_OFF, D2};
            SEL_2K:   r = {K_2K, D2};
            SEL_8K:   r = {K_8K, D2};
            SEL_DIG2: r = (p == PORT_F) ? {K_MAIN, D2} : {K_DIG2, D2};
            SEL_DIG1: r = (p == PORT_G) ? {K_MAIN, D2} : {K_DIG1, D2};
            SEL_M48:  r = (p == PORT_F) ? {K_MAIN1, D2} : {K_MAIN, D48};
            SEL_M16:  r = {K_MAIN, D16};
            SEL_M12:  r = {K_MAIN, D12};
            SEL_M8:   r = {K_MAIN, D8};
            SEL_M6:   r = {K_MAIN, D6};
            SEL_M4:   r = {K_MAIN, D4};
            SEL_A64:  r = (p == PORT_D || p == PORT_E) ? {K_AUX, D2} : {K_AUX, D64};
            SEL_A48:  r = {K_AUX, D48};
            SEL_A16:  r = {K_AUX, D16};
            SEL_A8:   r = {K_AUX, D8};
            SEL_A4:   r = {K_AUX, D4};
            default:  r = {K_OFF, D2};
        endcase
        return r;
    endfunction

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic [5:0] rt;
        assign code[p] = sel_q[p / 2][NIB * (p % 2) +: NIB];
        assign rt      = route(p, code[p]);
        always_comb begin
            case (rt[5:3])
                K_OFF:   out_d[p] = 1'b0;
                K_2K:    out_d[p] = dig_q[SYNC_SRC_BIT] ? aux_2k : main_2k;
                K_8K:    out_d[p] = dig_q[SYNC_SRC_BIT] ? aux_8k : main_8k;
                K_DIG2:  out_d[p] = prog_freq_second;
                K_DIG1:  out_d[p] = prog_freq_first;
                K_MAIN:  out_d[p] = msq[rt[2:0]];
                K_AUX:   out_d[p] = asq[rt[2:0]];
                K_MAIN1: out_d[p] = main_tick;
                default: out_d[p] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
        end else if (ce) begin
            out_q <= out_d;
        end
    end

    assign out_port_a = out_q[0];
    assign out_port_b = out_q[1];
    assign out_port_c = out_q[2];
    assign out_port_d = out_q[3];
    assign out_port_e = out_q[4];
    assign out_port_f = out_q[5];
    assign out_port_g = out_q[6];

    // ==========================================================
    // Assertions
    AST_MAIN_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && $past(ce) && $stable(main_q) |-> main_pll_code == main_q[MODE_LSB +: 3])
        else $error("main pll code does not follow mode field");
    AST_MAIN_BAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && main_q[MODE_LSB +: 3] >= MAIN_BAD_MIN ##1 ce |-> main_mode_bad)
        else $error("forbidden main mode not flagged");
    AST_BORROW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && main_q[BORROW_BIT] ##1 ce |->
        aux_pll_code == 3'({1'b0, $past(main_q[BORROW_FLSB +: 2])} + AUX_BORROW_OFS))
        else $error("borrowed aux code wrong");
    AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && wr_go && idx == REG_SEL_AB |=> sel_q[0] == $past(writedata[7:0]))
        else $error("selector write lost");
    AST_OFF_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && code[0] == SEL_OFF |=> !out_port_a)
        else $error("off port not low");
    AST_DIG1: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && code[0] == SEL_DIG1 |=> out_port_a == $past(prog_freq_first))
        else $error("first digital frequency not routed");
    AST_F_UNDIV: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && code[PORT_F] == SEL_M48 |=> out_port_f == $past(main_tick))
        else $error("port f undivided path wrong");
    AST_SYNC_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && code[0] == SEL_2K && dig_q[SYNC_SRC_BIT] |=> out_port_a == $past(aux_2k))
        else $error("2 kHz not from aux path");
    AST_PROG_CFG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && wr_go && idx == REG_DIGCFG ##1 ce ##1 ce |->
        prog_freq_first_cfg == {$past(writedata[DIG1_SONET], 2), $past(writedata[1:0], 2)})
        else $error("first digital config wrong");
    AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && (read || write) && waitrequest |=> !ce || !waitrequest)
        else $error("waitrequest not released");

    COV_WRITE: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_go && ce);
    COV_BORROW: cover property (@(posedge ref_clk) disable iff (!rst_n) main_q[BORROW_BIT]);
    COV_PORT_F1: cover property (@(posedge ref_clk) disable iff (!rst_n)
        code[PORT_F] == SEL_M48 && out_port_f);
endmodule
`default_nettype wire

/* File: sim/ocfs_equip.sv */
// Equipment model that counts rising edges on each selected output clock
`default_nettype none
module ocfs_equip (
    input  wire logic       ref_clk,
    input  wire logic       clr,
    input  wire logic [6:0] ports,
    output int              rises [7]
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] prev_q;
    // Edge counting tolerates any phase, so the bench need not know divider alignment
    always @(posedge ref_clk) begin
        prev_q <= ports;
        for (int i = 0; i < 7; i++) begin
            if (clr) rises[i] <= 0;
            else if (ports[i] === 1'b1 && prev_q[i] === 1'b0) rises[i] <= rises[i] + 1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the output clock frequency select block
`default_nettype none
module tb_top import ocfs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 1536;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0, clr = 1'b0;
    logic [9:0]  address = '0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic        waitrequest, mbad;
    logic        main_tick = 0, aux_tick = 0, main_2k = 0, main_8k = 0;
    logic        aux_2k = 0, aux_8k = 0, prog_freq_first = 0, prog_freq_second = 0;
    logic [6:0]  ports;
    logic [2:0]  mpc, apc, pf1, pf2;
    int          rises [7];
    int          error_cnt = 0;
    int          total_checks = 0;
    logic [31:0] seed = 32'h4b;

    always #25 ref_clk = ~ref_clk;

    ocfs_top i_ocfs_top (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .main_tick(main_tick), .aux_tick(aux_tick),
        .main_2k(main_2k), .main_8k(main_8k), .aux_2k(aux_2k), .aux_8k(aux_8k),
        .prog_freq_first(prog_freq_first), .prog_freq_second(prog_freq_second),
        .out_port_a(ports[0]), .out_port_b(ports[1]), .out_port_c(ports[2]),
        .out_port_d(ports[3]), .out_port_e(ports[4]), .out_port_f(ports[5]),
        .out_port_g(ports[6]), .main_pll_code(mpc), .main_mode_bad(mbad),
        .aux_pll_code(apc), .prog_freq_first_cfg(pf1), .prog_freq_second_cfg(pf2));

    ocfs_equip i_ocfs_equip (.ref_clk(ref_clk), .clr(clr), .ports(ports), .rises(rises));

    // ==========================================================
    // Reference model and compare tasks
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Kind: 0 off, 1 2k, 2 8k, 3 second, 4 first, 5 main div, 6 aux div, 7 main undivided
    function automatic void model(input int p, input int c, output int k, output int r);
        int mr [16] = '{0, 0, 0, 0, 0, 48, 16, 12, 8, 6, 4, 64, 48, 16, 8, 4};
        r = mr[c];
        k = (c < 5) ? c : ((c < 11) ? 5 : 6);
        if (p == PORT_F && c == 3) begin
            k = 5;
            r = 2;
        end
        if (p == PORT_F && c == 5) k = 7;
        if (p == PORT_G && c == 4) begin
            k = 5;
            r = 2;
        end
        if ((p == PORT_D || p == PORT_E) && c == 11) r = 2;
    endfunction

    function automatic logic lvl(input int k, input logic src, input logic [7:0] v);
        case (k)
            1: return src ? v[2] : v[0];
            2: return src ? v[3] : v[1];
            3: return v[5];
            4: return v[4];
            7: return v[6];
            default: return 1'b0;
        endcase
    endfunction

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // A divider shows ticks/ratio rising edges, give or take two at the window ends
    task automatic chk_cnt(input string name, input int ticks, input int ratio, input int got);
        total_checks++;
        if (got * ratio < ticks - 2 * ratio || got * ratio > ticks + 2 * ratio) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", name, ticks / ratio, got);
        end
    endtask

    // ==========================================================
    // Avalon master
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        if (wr) write <= 1'b1;
        else read <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk_val($sformatf("reg %0h", idx), {24'h0, exp & m}, q & {24'h0, m});
    endtask

    // ==========================================================
    // Output window: random sources in, levels and edge counts out
    task automatic run_window(input int base, input logic src);
        int k [7];
        int r [7];
        int mt;
        int at;
        logic [7:0] v1;
        logic [7:0] v2;
        logic [31:0] rnd;
        mt = 0;
        at = 0;
        v1 = '0;
        v2 = '0;
        for (int p = 0; p < 7; p++) model(p, (base + p) % 16, k[p], r[p]);
        clr <= 1'b1;
        for (int c = 0; c < WIN; c++) begin
            @(posedge ref_clk);
            for (int p = 0; p < 7; p++)
                if (c >= 3 && (k[p] < 5 || k[p] == 7))
                    chk_val($sformatf("port %0d", p), 32'(lvl(k[p], src, v2)), 32'(ports[p]));
            rnd = xs();
            v2 = v1;
            v1 = {rnd[16], rnd[1:0] != 2'b00, rnd[13:8]};
            {aux_tick, main_tick, prog_freq_second, prog_freq_first,
             aux_8k, aux_2k, main_8k, main_2k} <= v1;
            clr <= 1'b0;
            mt += int'(v1[6]);
            at += int'(v1[7]);
        end
        for (int p = 0; p < 7; p++)
            if (k[p] == 5 || k[p] == 6)
                chk_cnt($sformatf("rises %0d", p), (k[p] == 5) ? mt : at, r[p], rises[p]);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rv;
        logic [7:0]  mv;
        logic [7:0]  dv;
        logic [2:0]  md;
        logic [3:0]  cd [7];
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk_val("ports after reset", 32'h0, 32'(ports));
        for (int i = 0; i < 7; i++) rdchk(REG_SEL_AB + 8'(i), 8'h00, 8'hff);
        for (int i = 0; i < 16; i++) begin
            rv = xs();
            // Software never programs the two forbidden main codes
            md = 3'(i % 6);
            mv = {1'b0, i[3], rv[5:4], 1'b0, md};
            wr(REG_AUX_MODE, rv[15:8]);
            wr(REG_MAIN, mv);
            repeat (2) @(posedge ref_clk);
            chk_val("main code", 32'(md), 32'(mpc));
            chk_val("main bad", 32'(md >= 3'h6), 32'(mbad));
            chk_val("aux code", i[3] ? 32'({1'b0, rv[5:4]} + 3'h2) : 32'(rv[10:8]), 32'(apc));
            rdchk(REG_MAIN, mv, 8'h77);
            rdchk(REG_AUX_MODE, rv[15:8], 8'h07);
        end
        wr(8'h10, 8'ha5);
        rdchk(8'h10, 8'h00, 8'hff);
        for (int c = 0; c < 16; c++) begin
            rv = xs();
            dv = {c[0], 1'b0, rv[5:0]};
            for (int p = 0; p < 7; p++) cd[p] = 4'((c + p) % 16);
            wr(REG_DIGCFG, dv);
            wr(REG_SEL_AB, {cd[1], cd[0]});
            wr(REG_SEL_CD, {cd[3], cd[2]});
            wr(REG_SEL_EF, {cd[5], cd[4]});
            wr(REG_SEL_G, {4'h0, cd[6]});
            repeat (2) @(posedge ref_clk);
            chk_val("first cfg", 32'(dv[2:0]), 32'(pf1));
            chk_val("second cfg", 32'(dv[5:3]), 32'(pf2));
            rdchk(REG_SEL_CD, {cd[3], cd[2]}, 8'hff);
            rdchk(REG_SEL_G, {4'h0, cd[6]}, 8'h0f);
            run_window(c, dv[7]);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
